// >>> hw/tcc_timer2.sv
/*
 timer2 capture/compare block: 16-bit timer/counter, four capture and three compare channels.
 assumes an apb master on clk_in; pins are asynchronous and are synchronised here.
*/
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
module tcc_timer2
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // pins
    input wire logic count_pin_in,
    input wire logic [3:0] capture_input_in,
    output logic [7:0] port_out,
    // interrupt requests
    output logic timer_irq_out,
    output logic [6:0] ext_irq_out
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] timer_control_reg_q;
    logic [7:0] timer_select_reg_q;
    logic [7:0] clock_control_reg_q;
    logic [7:0] power_management_reg_q;
    logic [7:0] capture_edge_select_q;
    logic [7:0] extended_interrupt_flags_q;
    logic [7:0] extended_interrupt_enables_q;
    logic [7:0] compare_set_enable_q;
    logic [7:0] compare_reset_toggle_enable_q;
    logic [15:0] count_q;
    logic [15:0] reload_q;
    logic [15:0] capture_q [4];
    logic [15:0] compare_q [3];
    logic [5:0] port_latch_q;
    logic [2:0] match_q;
    logic [9:0] div_cnt_q;
    logic [2:0] pre_cnt_q;
    logic [1:0] cnt_sync_q;
    logic cnt_prev_q;
    logic [3:0] cap_sync1_q;
    logic [3:0] cap_sync2_q;
    logic [3:0] cap_prev_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic timer_irq_q;
    logic [6:0] ext_irq_q;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire access_w = psel_in && penable_in && !pready_q;
    wire wr_w = access_w && pwrite_in;
    wire wr_tc = wr_w && paddr_in == tcc_pkg::TIMER_CONTROL_OFF;
    wire wr_ts = wr_w && paddr_in == tcc_pkg::TIMER_SELECT_OFF;
    wire wr_ck = wr_w && paddr_in == tcc_pkg::CLOCK_CONTROL_OFF;
    wire wr_pm = wr_w && paddr_in == tcc_pkg::POWER_MGMT_OFF;
    wire wr_cnt = wr_w && paddr_in == tcc_pkg::COUNT_OFF;
    wire wr_rl = wr_w && paddr_in == tcc_pkg::RELOAD_OFF;
    wire wr_ce = wr_w && paddr_in == tcc_pkg::CAPTURE_EDGE_OFF;
    wire wr_if = wr_w && paddr_in == tcc_pkg::IRQ_FLAGS_OFF;
    wire wr_ie = wr_w && paddr_in == tcc_pkg::IRQ_ENABLES_OFF;
    wire wr_se = wr_w && paddr_in == tcc_pkg::SET_ENABLE_OFF;
    wire wr_rt = wr_w && paddr_in == tcc_pkg::RESET_TOGGLE_OFF;
    wire wr_port = wr_w && paddr_in == tcc_pkg::PORT_OFF;
    wire [7:0] wb = pwdata_in[7:0];
    wire cap_area = paddr_in[7:4] == tcc_pkg::CAPTURE_BASE_OFF[7:4];
    wire cmp_area = paddr_in[7:4] == tcc_pkg::COMPARE_BASE_OFF[7:4]
                    && paddr_in[3:2] != 2'b11;
    wire [1:0] sub_idx = paddr_in[3:2];

    // ------------------------------------------------------------
    // clock source and prescaler
    // ------------------------------------------------------------
    wire run_w = timer_control_reg_q[tcc_pkg::RUN_POS];
    wire cnt_sel_w = timer_control_reg_q[tcc_pkg::CNT_SEL_POS];
    wire [1:0] sys_div_w = {power_management_reg_q[tcc_pkg::DIV_HI_POS],
                            power_management_reg_q[tcc_pkg::DIV_LO_POS]};
    wire rate_w = clock_control_reg_q[tcc_pkg::RATE_SEL_POS];
    logic [9:0] div_limit;
    always_comb
    begin
        case (sys_div_w)
            2'b11: div_limit = tcc_pkg::DIV_SLOW;
            2'b00: div_limit = power_management_reg_q[tcc_pkg::MUL4_POS] ?
                               tcc_pkg::DIV_FULL : tcc_pkg::DIV_HALF;
            default: div_limit = rate_w ? tcc_pkg::DIV_QUARTER : tcc_pkg::DIV_TWELVE;
        endcase
    end
    wire sys_tick = div_cnt_q >= div_limit;
    wire ext_tick = cnt_prev_q && !cnt_sync_q[1];
    wire src_tick = cnt_sel_w ? ext_tick : sys_tick;
    logic [2:0] pre_mask;
    always_comb
    begin
        case (timer_select_reg_q[1:0])
            2'b00: pre_mask = 3'h0;
            2'b01: pre_mask = 3'h1;
            2'b10: pre_mask = 3'h3;
            default: pre_mask = 3'h7;
        endcase
    end
    wire pre_tick = src_tick && ((pre_cnt_q & pre_mask) == pre_mask);
    wire inc_w = run_w && pre_tick;
    wire [15:0] count_next = count_q + 16'h0001;
    wire low_ovf = inc_w && count_q[7:0] == 8'hFF;
    wire full_ovf = inc_w && count_q == 16'hFFFF;

    // ------------------------------------------------------------
    // capture edges and compare matches
    // ------------------------------------------------------------
    logic [3:0] cap_hit;
    logic [2:0] cmp_hit;
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_cap
            wire fall = cap_prev_q[g] && !cap_sync2_q[g];
            wire rise = !cap_prev_q[g] && cap_sync2_q[g];
            assign cap_hit[g] = (fall && capture_edge_select_q[2*g+1]) ||
                                (rise && capture_edge_select_q[2*g]);
        end
        for (g = 0; g < 3; g++)
        begin : g_cmp
            assign cmp_hit[g] = inc_w && count_next == compare_q[g];
        end
    endgenerate

    // port output: toggle flip-flops drive the top two bits
    wire [7:0] port_w = {compare_set_enable_q[7:6], port_latch_q};
    logic [5:0] port_d;
    always_comb
    begin
        port_d = port_latch_q;
        if (wr_port)
        begin
            port_d = wb[5:0];
        end
        if (match_q[0])
        begin
            port_d = port_d | compare_set_enable_q[5:0];
        end
        if (match_q[1])
        begin
            port_d = port_d & ~compare_reset_toggle_enable_q[5:0];
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    logic [31:0] rd_d;
    logic rd_err;
    always_comb
    begin
        rd_d = 32'h0000_0000;
        rd_err = 1'b0;
        if (cap_area)
        begin
            rd_d = {16'h0000, capture_q[sub_idx]};
        end
        else if (cmp_area)
        begin
            rd_d = {16'h0000, compare_q[sub_idx]};
        end
        else
        begin
            case (paddr_in)
                tcc_pkg::TIMER_CONTROL_OFF: rd_d = {24'h00_0000, timer_control_reg_q};
                tcc_pkg::TIMER_SELECT_OFF: rd_d = {24'h00_0000, timer_select_reg_q};
                tcc_pkg::CLOCK_CONTROL_OFF: rd_d = {24'h00_0000, clock_control_reg_q};
                tcc_pkg::POWER_MGMT_OFF: rd_d = {24'h00_0000, power_management_reg_q};
                tcc_pkg::COUNT_OFF: rd_d = {16'h0000, count_q};
                tcc_pkg::RELOAD_OFF: rd_d = {16'h0000, reload_q};
                tcc_pkg::CAPTURE_EDGE_OFF: rd_d = {24'h00_0000, capture_edge_select_q};
                tcc_pkg::IRQ_FLAGS_OFF: rd_d = {24'h00_0000, extended_interrupt_flags_q};
                tcc_pkg::IRQ_ENABLES_OFF: rd_d = {24'h00_0000, extended_interrupt_enables_q};
                tcc_pkg::SET_ENABLE_OFF: rd_d = {24'h00_0000, compare_set_enable_q};
                tcc_pkg::RESET_TOGGLE_OFF: rd_d = {24'h00_0000, compare_reset_toggle_enable_q};
                tcc_pkg::PORT_OFF: rd_d = {24'h00_0000, port_w};
                default: rd_err = 1'b1;
            endcase
        end
    end

    // ------------------------------------------------------------
    // next values of flag registers
    // ------------------------------------------------------------
    logic [7:0] tc_d;
    logic [7:0] ts_d;
    logic [7:0] eif_d;
    logic [7:0] se_d;
    always_comb
    begin
        tc_d = wr_tc ? wb : timer_control_reg_q;
        ts_d = wr_ts ? wb : timer_select_reg_q;
        eif_d = wr_if ? wb : extended_interrupt_flags_q;
        se_d = wr_se ? wb : compare_set_enable_q;
        // hardware sets win over software clears; nothing clears them here
        tc_d[tcc_pkg::FULL_OVF_POS] = tc_d[tcc_pkg::FULL_OVF_POS] | full_ovf;
        ts_d[tcc_pkg::LOW_OVF_POS] = ts_d[tcc_pkg::LOW_OVF_POS] | low_ovf | full_ovf;
        eif_d[3:0] = eif_d[3:0] | cap_hit;
        eif_d[6:4] = eif_d[6:4] | match_q;
        eif_d[7] = 1'b0;
        if (match_q[2])
        begin
            se_d[7:6] = se_d[7:6] ^ compare_reset_toggle_enable_q[7:6];
        end
    end

    wire timer_req = extended_interrupt_enables_q[tcc_pkg::TIMER_IE_POS] &&
        ((timer_select_reg_q[tcc_pkg::LOW_OVF_POS] && timer_select_reg_q[tcc_pkg::LOW_REQ_POS])
        || (timer_control_reg_q[tcc_pkg::FULL_OVF_POS]
        && timer_select_reg_q[tcc_pkg::FULL_REQ_POS]));

    // ------------------------------------------------------------
    // pin synchronisers and dividers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            cnt_sync_q <= 2'b11;
            cnt_prev_q <= 1'b1;
            cap_sync1_q <= 4'h0;
            cap_sync2_q <= 4'h0;
            cap_prev_q <= 4'h0;
        end
        else
        begin
            cnt_sync_q <= {cnt_sync_q[0], count_pin_in};
            cnt_prev_q <= cnt_sync_q[1];
            cap_sync1_q <= capture_input_in;
            cap_sync2_q <= cap_sync1_q;
            cap_prev_q <= cap_sync2_q;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            div_cnt_q <= 10'h000;
            pre_cnt_q <= 3'h0;
        end
        else
        begin
            div_cnt_q <= sys_tick ? 10'h000 : div_cnt_q + 10'h001;
            pre_cnt_q <= src_tick ? pre_cnt_q + 3'h1 : pre_cnt_q;
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            timer_control_reg_q <= tcc_pkg::CTRL_RESET;
            timer_select_reg_q <= tcc_pkg::CTRL_RESET;
            clock_control_reg_q <= tcc_pkg::CTRL_RESET;
            power_management_reg_q <= tcc_pkg::POWER_RESET;
            capture_edge_select_q <= tcc_pkg::CTRL_RESET;
            extended_interrupt_flags_q <= tcc_pkg::CTRL_RESET;
            extended_interrupt_enables_q <= tcc_pkg::CTRL_RESET;
            compare_set_enable_q <= tcc_pkg::CTRL_RESET;
            compare_reset_toggle_enable_q <= tcc_pkg::CTRL_RESET;
        end
        else
        begin
            timer_control_reg_q <= tc_d;
            timer_select_reg_q <= ts_d;
            clock_control_reg_q <= wr_ck ? wb : clock_control_reg_q;
            power_management_reg_q <= wr_pm ? wb : power_management_reg_q;
            capture_edge_select_q <= wr_ce ? wb : capture_edge_select_q;
            extended_interrupt_flags_q <= eif_d;
            extended_interrupt_enables_q <= wr_ie ? wb : extended_interrupt_enables_q;
            compare_set_enable_q <= se_d;
            compare_reset_toggle_enable_q <= wr_rt ? wb : compare_reset_toggle_enable_q;
        end
    end

    // ------------------------------------------------------------
    // timer state
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            count_q <= tcc_pkg::WORD_RESET;
            reload_q <= tcc_pkg::WORD_RESET;
            port_latch_q <= tcc_pkg::PORT_RESET[5:0];
            match_q <= 3'h0;
        end
        else
        begin
            reload_q <= wr_rl ? pwdata_in[15:0] : reload_q;
            count_q <= wr_cnt ? pwdata_in[15:0] : (inc_w ? count_next : count_q);
            port_latch_q <= port_d;
            match_q <= cmp_hit;
        end
    end

    generate
        for (g = 0; g < 4; g++)
        begin : g_cap_reg
            always_ff @(posedge clk_in or negedge reset_n_in)
            begin
                if (!reset_n_in)
                begin
                    capture_q[g] <= tcc_pkg::WORD_RESET;
                end
                else if (cap_hit[g])
                begin
                    capture_q[g] <= count_q;
                end
            end
        end
        for (g = 0; g < 3; g++)
        begin : g_cmp_reg
            always_ff @(posedge clk_in or negedge reset_n_in)
            begin
                if (!reset_n_in)
                begin
                    compare_q[g] <= tcc_pkg::WORD_RESET;
                end
                else if (wr_w && cmp_area && sub_idx == 2'(g))
                begin
                    compare_q[g] <= pwdata_in[15:0];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // bus answer and outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            port_out <= tcc_pkg::PORT_RESET;
            timer_irq_q <= 1'b0;
            ext_irq_q <= 7'h00;
        end
        else
        begin
            pready_q <= access_w;
            pslverr_q <= access_w && rd_err;
            prdata_q <= (access_w && !pwrite_in) ? rd_d : 32'h0000_0000;
            port_out <= port_w;
            timer_irq_q <= timer_req;
            ext_irq_q <= extended_interrupt_flags_q[6:0] & extended_interrupt_enables_q[6:0];
        end
    end

    assign prdata_out = prdata_q;
    assign pready_out = pready_q;
    assign pslverr_out = pslverr_q;
    assign timer_irq_out = timer_irq_q;
    assign ext_irq_out = ext_irq_q;
endmodule : tcc_timer2

// >>> hw/tcc_pkg.sv
/*
 timer2 capture/compare package: register offsets, field positions, reset values.
 assumes an apb slave with 32-bit data and one aligned word per register.
*/
package tcc_pkg;
    // register byte offsets
    localparam logic [7:0] TIMER_CONTROL_OFF = 8'h00;
    localparam logic [7:0] TIMER_SELECT_OFF = 8'h04;
    localparam logic [7:0] CLOCK_CONTROL_OFF = 8'h08;
    localparam logic [7:0] POWER_MGMT_OFF = 8'h0C;
    localparam logic [7:0] COUNT_OFF = 8'h10;
    localparam logic [7:0] RELOAD_OFF = 8'h14;
    localparam logic [7:0] CAPTURE_EDGE_OFF = 8'h18;
    localparam logic [7:0] IRQ_FLAGS_OFF = 8'h1C;
    localparam logic [7:0] IRQ_ENABLES_OFF = 8'h20;
    localparam logic [7:0] SET_ENABLE_OFF = 8'h24;
    localparam logic [7:0] RESET_TOGGLE_OFF = 8'h28;
    localparam logic [7:0] CAPTURE_BASE_OFF = 8'h30;
    localparam logic [7:0] COMPARE_BASE_OFF = 8'h40;
    localparam logic [7:0] PORT_OFF = 8'h4C;
    // field positions
    localparam int FULL_OVF_POS = 7;
    localparam int RUN_POS = 2;
    localparam int CNT_SEL_POS = 1;
    localparam int FULL_REQ_POS = 7;
    localparam int LOW_REQ_POS = 6;
    localparam int LOW_OVF_POS = 4;
    localparam int RATE_SEL_POS = 5;
    localparam int DIV_HI_POS = 7;
    localparam int DIV_LO_POS = 6;
    localparam int MUL4_POS = 3;
    localparam int TIMER_IE_POS = 7;
    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] POWER_RESET = 8'h80;
    localparam logic [7:0] PORT_RESET = 8'hFF;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    // system clock divide counts (clock_rate: machine cycle when rate select = 0)
    localparam logic [9:0] DIV_FULL = 10'h000;
    localparam logic [9:0] DIV_HALF = 10'h001;
    localparam logic [9:0] DIV_QUARTER = 10'h003;
    localparam logic [9:0] DIV_TWELVE = 10'h00B;
    localparam logic [9:0] DIV_SLOW = 10'h3FF;
endpackage : tcc_pkg

// >>> test/tcc_timer2_assertions.sv
/*
 checker for tcc_timer2: apb answer timing, error and read data shape, sticky requests.
 assumes a bind onto tcc_timer2; it sees only the ports of that module.
*/
`timescale 1ns/1ns
module tcc_timer2_assertions
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // apb
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // pins and requests
    input wire logic count_pin_in,
    input wire logic [3:0] capture_input_in,
    input wire logic [7:0] port_out,
    input wire logic timer_irq_out,
    input wire logic [6:0] ext_irq_out
);
    // ----------------
    // helpers
    // ----------------
    logic acc;
    logic acc_wr;
    logic mapped;
    assign acc = psel_in && penable_in;
    assign acc_wr = acc && pwrite_in;
    assign mapped = paddr_in[1:0] == 2'b00 && paddr_in != 8'h2C && paddr_in <= 8'h4C;
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);
    // ----------------
    // properties
    // ----------------
    AST_READY_AFTER_ACCESS: assert property (acc && !pready_out |=> pready_out)
        else $error("no answer one cycle after access start");
    AST_READY_ONE_CYCLE: assert property (pready_out |=> !pready_out)
        else $error("pready held longer than one cycle");
    AST_READY_CAUSE: assert property (pready_out |-> $past(acc))
        else $error("pready without an access phase");
    AST_ERR_WITH_READY: assert property (pslverr_out |-> pready_out)
        else $error("pslverr outside the answer cycle");
    AST_RDATA_IDLE: assert property (!pready_out |-> prdata_out == 32'h0000_0000)
        else $error("read data not zero outside the answer cycle");
    AST_ERR_MAPPED: assert property (pready_out && $past(mapped) |-> !pslverr_out)
        else $error("error answer on a mapped address");
    AST_ERR_HOLE: assert property (pready_out && $past(paddr_in) == 8'h2C |-> pslverr_out)
        else $error("no error answer on an unmapped address");
    AST_RDATA_WIDTH: assert property (pready_out && !$past(pwrite_in) |-> prdata_out[31:16] == 16'h0000)
        else $error("read data wider than any register");
    AST_TIMER_REQ_STICKY: assert property ($fell(timer_irq_out) |-> $past(acc_wr) || $past(acc_wr, 2) || $past(acc_wr, 3))
        else $error("timer request dropped without a software write");
    AST_EXT_REQ_STICKY: assert property ((|($past(ext_irq_out) & ~ext_irq_out)) |-> $past(acc_wr) || $past(acc_wr, 2) || $past(acc_wr, 3))
        else $error("extended request dropped without a software write");
endmodule : tcc_timer2_assertions
bind tcc_timer2 tcc_timer2_assertions u_chk (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .count_pin_in(count_pin_in), .capture_input_in(capture_input_in),
    .port_out(port_out), .timer_irq_out(timer_irq_out), .ext_irq_out(ext_irq_out));

// >>> test/tcc_pin_model.sv
/*
 pin model for tcc_timer2: external count pin and four capture pins.
 assumes the bench calls its tasks; pins change just after a rising clock edge.
*/
`timescale 1ns/1ns
module tcc_pin_model
(
    // clock
    input wire logic clk_in,
    // pins toward the timer
    output logic count_pin_out,
    output logic [3:0] capture_out
);
    initial
    begin
        count_pin_out = 1'b1;
        capture_out = 4'h0;
    end
    // each level held long enough for the synchroniser, then settle time
    task automatic pulse_count(input int n);
        repeat (n)
        begin
            @(posedge clk_in);
            count_pin_out <= 1'b0;
            repeat (3) @(posedge clk_in);
            count_pin_out <= 1'b1;
            repeat (2) @(posedge clk_in);
        end
        repeat (4) @(posedge clk_in);
    endtask : pulse_count
    task automatic drive_capture(input logic [3:0] v);
        @(posedge clk_in);
        capture_out <= v;
        repeat (6) @(posedge clk_in);
    endtask : drive_capture
endmodule : tcc_pin_model

// >>> test/tcc_timer2_test.sv
/*
 bench for tcc_timer2: apb register sequences with expected values.
 assumes the pin model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ns
module tcc_timer2_test;
    logic clk_in, reset_n_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
    logic timer_irq_out, count_pin_in;
    logic [7:0] paddr_in, port_out;
    logic [31:0] pwdata_in, prdata_out, rd;
    logic [3:0] capture_input_in;
    logic [6:0] ext_irq_out;
    logic err;
    int bad_count, samples_checked;
    tcc_timer2 u_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .count_pin_in(count_pin_in),
        .capture_input_in(capture_input_in), .port_out(port_out),
        .timer_irq_out(timer_irq_out), .ext_irq_out(ext_irq_out));
    tcc_pin_model u_pins (.clk_in(clk_in), .count_pin_out(count_pin_in),
        .capture_out(capture_input_in));
    always #2 clk_in = ~clk_in;
    // ----------------
    // tasks
    // ----------------
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= wd;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (pready_out !== 1'b1 && n < 16);
        if (n >= 16)
        begin
            bad_count++;
            finish_test();
        end
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0000_0000);
        check(what, rd, exp);
    endtask : rd_chk
    initial
    begin
        repeat (5000) @(posedge clk_in);
        bad_count++;
        finish_test();
    end
    // ----------------
    // sequence
    // ----------------
    initial
    begin
        clk_in = 1'b0;
        reset_n_in = 1'b0;
        {psel_in, penable_in, pwrite_in} = 3'b000;
        paddr_in = 8'h00;
        pwdata_in = 32'h0000_0000;
        repeat (6) @(posedge clk_in);
        reset_n_in <= 1'b1;
        rd_chk(tcc_pkg::TIMER_CONTROL_OFF, 32'h0000_0000, "timer_control");
        rd_chk(tcc_pkg::POWER_MGMT_OFF, 32'h0000_0080, "power_management");
        check("port_out", {24'h0, port_out}, 32'h0000_003F);
        wr(8'h2C, 32'hFFFF_FFFF);
        check("write error", {31'h0, err}, 32'h0000_0001);
        rd_chk(8'h2C, 32'h0000_0000, "unmapped read");
        check("read error", {31'h0, err}, 32'h0000_0001);
        for (int i = 0; i < 4; i++)
        begin
            wr(tcc_pkg::RELOAD_OFF + 8'(i * 4 + i / 2 * 8), 32'h0000_00A5);
            rd_chk(tcc_pkg::RELOAD_OFF + 8'(i * 4 + i / 2 * 8), 32'h0000_00A5,
                "rw register");
            wr(tcc_pkg::RELOAD_OFF + 8'(i * 4 + i / 2 * 8), 32'h0000_0000);
        end
        wr(tcc_pkg::TIMER_CONTROL_OFF, 32'h0000_0006);
        for (int p = 0; p < 4; p++)
        begin
            wr(tcc_pkg::TIMER_SELECT_OFF, 32'(p));
            wr(tcc_pkg::COUNT_OFF, 32'h0000_0000);
            u_pins.pulse_count(8);
            rd_chk(tcc_pkg::COUNT_OFF, 32'(8 >> p), "prescaled count");
        end
        wr(tcc_pkg::IRQ_ENABLES_OFF, 32'h0000_0080);
        wr(tcc_pkg::TIMER_SELECT_OFF, 32'h0000_00C0);
        wr(tcc_pkg::COUNT_OFF, 32'h0000_00FF);
        u_pins.pulse_count(1);
        rd_chk(tcc_pkg::COUNT_OFF, 32'h0000_0100, "carry");
        rd_chk(tcc_pkg::TIMER_SELECT_OFF, 32'h0000_00D0, "low overflow");
        rd_chk(tcc_pkg::TIMER_CONTROL_OFF, 32'h0000_0006, "no full overflow");
        check("timer request low", {31'h0, timer_irq_out}, 32'h0000_0001);
        wr(tcc_pkg::TIMER_SELECT_OFF, 32'h0000_0080);
        repeat (3) @(posedge clk_in);
        check("request cleared", {31'h0, timer_irq_out}, 32'h0000_0000);
        wr(tcc_pkg::COUNT_OFF, 32'h0000_FFFF);
        u_pins.pulse_count(1);
        rd_chk(tcc_pkg::TIMER_CONTROL_OFF, 32'h0000_0086, "full overflow");
        rd_chk(tcc_pkg::TIMER_SELECT_OFF, 32'h0000_0090, "both flags");
        rd_chk(tcc_pkg::IRQ_FLAGS_OFF, 32'h0000_0070, "compare flags");
        check("port untouched", {24'h0, port_out}, 32'h0000_003F);
        repeat (20) @(posedge clk_in);
        check("request held", {31'h0, timer_irq_out}, 32'h0000_0001);
        wr(tcc_pkg::TIMER_CONTROL_OFF, 32'h0000_0002);
        repeat (3) @(posedge clk_in);
        check("request cleared", {31'h0, timer_irq_out}, 32'h0000_0000);
        wr(tcc_pkg::COUNT_OFF, 32'h0000_0000);
        u_pins.pulse_count(3);
        rd_chk(tcc_pkg::COUNT_OFF, 32'h0000_0000, "stopped count");
        wr(tcc_pkg::POWER_MGMT_OFF, 32'h0000_0008);
        wr(tcc_pkg::TIMER_CONTROL_OFF, 32'h0000_0004);
        wr(tcc_pkg::TIMER_CONTROL_OFF, 32'h0000_0000);
        rd_chk(tcc_pkg::COUNT_OFF, 32'h0000_0004, "clock count");
        wr(tcc_pkg::IRQ_FLAGS_OFF, 32'h0000_0000);
        wr(tcc_pkg::COUNT_OFF, 32'h0000_1234);
        wr(tcc_pkg::CAPTURE_EDGE_OFF, 32'h0000_0039);
        wr(tcc_pkg::IRQ_ENABLES_OFF, 32'h0000_000F);
        u_pins.drive_capture(4'hF);
        rd_chk(tcc_pkg::IRQ_FLAGS_OFF, 32'h0000_0005, "rising flags");
        wr(tcc_pkg::COUNT_OFF, 32'h0000_2222);
        u_pins.drive_capture(4'h0);
        rd_chk(tcc_pkg::IRQ_FLAGS_OFF, 32'h0000_0007, "falling flags");
        check("ext request", {25'h0, ext_irq_out}, 32'h0000_0007);
        rd_chk(tcc_pkg::CAPTURE_BASE_OFF, 32'h0000_1234, "capture 0");
        rd_chk(tcc_pkg::CAPTURE_BASE_OFF + 8'h04, 32'h0000_2222, "capture 1");
        rd_chk(tcc_pkg::CAPTURE_BASE_OFF + 8'h08, 32'h0000_2222, "capture 2");
        rd_chk(tcc_pkg::CAPTURE_BASE_OFF + 8'h0C, 32'h0000_0000, "capture 3");
        wr(tcc_pkg::IRQ_FLAGS_OFF, 32'h0000_0000);
        wr(tcc_pkg::IRQ_ENABLES_OFF, 32'h0000_0070);
        wr(tcc_pkg::COUNT_OFF, 32'h0000_0000);
        wr(tcc_pkg::COMPARE_BASE_OFF, 32'h0000_0005);
        wr(tcc_pkg::COMPARE_BASE_OFF + 8'h04, 32'h0000_0007);
        wr(tcc_pkg::COMPARE_BASE_OFF + 8'h08, 32'h0000_0009);
        wr(tcc_pkg::PORT_OFF, 32'h0000_0000);
        wr(tcc_pkg::SET_ENABLE_OFF, 32'h0000_0005);
        wr(tcc_pkg::RESET_TOGGLE_OFF, 32'h0000_0081);
        wr(tcc_pkg::TIMER_CONTROL_OFF, 32'h0000_0006);
        u_pins.pulse_count(5);
        check("port set", {24'h0, port_out}, 32'h0000_0005);
        check("compare request", {25'h0, ext_irq_out}, 32'h0000_0010);
        u_pins.pulse_count(2);
        check("port reset", {24'h0, port_out}, 32'h0000_0004);
        u_pins.pulse_count(2);
        check("port toggle", {24'h0, port_out}, 32'h0000_0084);
        rd_chk(tcc_pkg::SET_ENABLE_OFF, 32'h0000_0085, "toggle bits");
        rd_chk(tcc_pkg::IRQ_FLAGS_OFF, 32'h0000_0070, "compare flags");
        reset_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        check("port in reset", {24'h0, port_out}, 32'h0000_00FF);
        reset_n_in <= 1'b1;
        rd_chk(tcc_pkg::SET_ENABLE_OFF, 32'h0000_0000, "set enable after reset");
        check("port after reset", {24'h0, port_out}, 32'h0000_003F);
        finish_test();
    end
endmodule : tcc_timer2_test
